// [rtl/sdma_regs.svh]
// Register offsets, descriptor layout, field positions and reset values
`ifndef SDMA_REGS_SVH
`define SDMA_REGS_SVH
`define SDMA_CTRL_OFS      12'h000
`define SDMA_STAT_OFS      12'h004
`define SDMA_IRQ_STAT_OFS  12'h008
`define SDMA_IRQ_MASK_OFS  12'h00C
`define SDMA_GO_OFS        12'h010
`define SDMA_DESC_BASE     12'h100
`define SDMA_DESC_BYTES    32
`define SDMA_CTRL_RUN_BIT  0
`define SDMA_CTRL_LINK_LSB 8
`define SDMA_GO_BIT        0
`define SDMA_F_AUTO        0
`define SDMA_F_WMETA       1
`define SDMA_F_INCR        2
`define SDMA_F_SOP         3
`define SDMA_F_EOP         4
`define SDMA_F_LINK_INT    5
`define SDMA_F_CHAIN_INT   6
`define SDMA_F_CHAIN_END   7
`define SDMA_IRQ_LINK_BIT  0
`define SDMA_IRQ_CHAIN_BIT 1
`define SDMA_IRQ_MASK_RST  2'h0
`define SDMA_IRQ_STAT_RST  2'h0
`define SDMA_DESC_RST      32'h0
`define SDMA_BEAT_BYTES    3'h4
`define SDMA_META_STEP     64'h4
`endif

// [rtl/sdma_pkg.sv]
// Types shared by the descriptor DMA modules
package sdma_pkg;
  typedef enum logic [6:0] {
    SDMA_IDLE = 7'h01,
    SDMA_LOAD = 7'h02,
    SDMA_GO   = 7'h04,
    SDMA_XFER = 7'h08,
    SDMA_META = 7'h10,
    SDMA_DATA = 7'h20,
    SDMA_DONE = 7'h40
  } sdma_state_e;
  // Word 0 at the low end
  typedef struct packed {
    logic [31:0] incr;
    logic [31:0] loops;
    logic [31:0] flags;
    logic [31:0] bytes;
    logic [63:0] meta;
    logic [63:0] dst;
  } sdma_desc_s;
  typedef struct packed {
    logic        valid;
    logic        sop;
    logic        eop;
    logic [31:0] meta;
    logic [31:0] data;
  } sdma_beat_s;
  typedef struct packed {
    logic        valid;
    logic        first;
    logic        last;
    logic [63:0] addr;
    logic [3:0]  keep;
    logic [31:0] data;
  } sdma_wr_s;
  typedef struct packed {
    logic [11:0] address;
    logic        read;
    logic        write;
    logic [3:0]  byteenable;
    logic [31:0] writedata;
  } sdma_avm_s;

  function automatic logic [31:0] sdma_be_merge(input logic [31:0] old_w, input logic [31:0] new_w,
                                                input logic [3:0] be);
    logic [31:0] r;
    r = old_w;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[i*8 +: 8] = new_w[i*8 +: 8];
    end
    return r;
  endfunction : sdma_be_merge
endpackage : sdma_pkg

// [rtl/sdma_desc_ram.sv]
// Descriptor memory: one bus port, one whole-descriptor read port
`timescale 1ns/100ps
`include "sdma_regs.svh"
module sdma_desc_ram #(
  parameter int DESC_NUM = 16,
  parameter int AW       = 7,
  parameter int LW       = 4
) (
  // Clock and reset
  input  wire logic                 core_clk_i,
  input  wire logic                 sys_rst_i,
  // Bus side
  input  wire logic                 we_i,
  input  wire logic [AW-1:0]        idx_i,
  input  wire logic [31:0]          wdata_i,
  input  wire logic [3:0]           be_i,
  output logic      [31:0]          rdata_o,
  // Engine side
  input  wire logic [LW-1:0]        link_i,
  output sdma_pkg::sdma_desc_s      desc_o
);
  import sdma_pkg::*;
  typedef struct packed {
    logic [DESC_NUM*8-1:0][31:0] mem;
  } sdma_ram_s;
  sdma_ram_s s, next_s;

  always_comb begin
    next_s = s;
    if (we_i) next_s.mem[idx_i] = sdma_be_merge(s.mem[idx_i], wdata_i, be_i);
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < DESC_NUM * 8; i++) s.mem[i] <= `SDMA_DESC_RST;
    end else begin
      s <= next_s;
    end
  end

  // Small array, so flops with combinational reads
  assign rdata_o = s.mem[idx_i];
  assign desc_o  = sdma_desc_s'(s.mem[{link_i, 3'h0} +: 8]);
endmodule : sdma_desc_ram

// [rtl/sdma_irq.sv]
// Sticky interrupt status with mask and level output
`timescale 1ns/100ps
`include "sdma_regs.svh"
module sdma_irq #(
  parameter int N = 2
) (
  // Clock and reset
  input  wire logic          core_clk_i,
  input  wire logic          sys_rst_i,
  // Events and software access
  input  wire logic [N-1:0]  set_i,
  input  wire logic [N-1:0]  clr_i,
  input  wire logic          mask_we_i,
  input  wire logic [N-1:0]  mask_i,
  // State
  output logic      [N-1:0]  status_o,
  output logic      [N-1:0]  mask_o,
  output logic               irq_o
);
  import sdma_pkg::*;
  typedef struct packed {
    logic [N-1:0] stat;
    logic [N-1:0] mask;
    logic         irq;
  } sdma_irq_s;
  sdma_irq_s s, next_s;

  always_comb begin
    next_s = s;
    // Set after clear so a same-cycle event survives
    next_s.stat = (s.stat & ~clr_i) | set_i;
    if (mask_we_i) next_s.mask = mask_i;
    next_s.irq = |(next_s.stat & next_s.mask);
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s.stat <= N'(`SDMA_IRQ_STAT_RST);
      s.mask <= N'(`SDMA_IRQ_MASK_RST);
      s.irq  <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  assign status_o = s.stat;
  assign mask_o   = s.mask;
  assign irq_o    = s.irq;

  set_wins_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    set_i[0] |=> status_o[0])
    else $error("event lost against clear");
endmodule : sdma_irq

// [rtl/sdma_top.sv]
// Stream-to-PCIe chained descriptor DMA engine with Avalon-MM slave
// What this block does
// - The descriptor's auto flag starts it at once, otherwise it waits for a software go.
// - With metadata writing off, no metadata request leaves the engine for that descriptor.
// - With metadata writing on, stream metadata goes to the descriptor's own metadata address, which moves up 4 bytes after each metadata write.
// - Stream data is written from the descriptor's destination start address onward.
// - Exactly the programmed byte count of stream data is sent to the PCIe side for each execution not ended early by an end-of-packet marker.
// - In loop mode the descriptor runs as many times as its loop length, and once for a loop length of zero.
// - In loop mode the loop increment is added to the destination after each execution.
// - In loop mode the chain moves on only after all repetitions are done.
// - With start-on-packet-start on, data before a start-of-packet marker is skipped.
// - With end-on-packet-end on, an end-of-packet marker ends the execution.
// - With the link interrupt enabled, each finished execution raises an interrupt.
// - With the chain interrupt enabled, the end of the whole chain raises an interrupt.
// - A descriptor without the chain-end flag is followed by the next one, else the engine stops.
//
// The implementer's own choices: the Avalon-MM register port and the register addresses.
`timescale 1ns/100ps
`include "sdma_regs.svh"
module sdma_top #(
  parameter int DESC_NUM = 16
) (
  // Clock and reset
  input  wire logic                 core_clk_i,
  input  wire logic                 sys_rst_i,
  // Avalon-MM register slave
  input  wire sdma_pkg::sdma_avm_s  avs_i,
  output logic [31:0]               avs_readdata_o,
  output logic                      avs_waitrequest_o,
  // Input stream
  input  wire sdma_pkg::sdma_beat_s st_i,
  output logic                      st_ready_o,
  // PCIe write requests
  output sdma_pkg::sdma_wr_s        wr_o,
  input  wire logic                 wr_ready_i,
  input  wire logic [2:0]           mps_i,
  // Interrupt
  output logic                      irq_o
);
  import sdma_pkg::*;
  localparam int LW = $clog2(DESC_NUM);
  localparam int AW = $clog2(DESC_NUM * 8);

  typedef struct packed {
    sdma_state_e fsm;
    logic        wreq;
    logic [31:0] rdata;
    logic [LW-1:0] link;
    sdma_desc_s  d;
    logic [63:0] base;
    logic [63:0] addr;
    logic [63:0] mptr;
    logic [31:0] left;
    logic [31:0] loops;
    logic [12:0] req;
    logic        armed;
    logic        go;
    sdma_beat_s  beat;
    logic        rdy;
    sdma_wr_s    wr;
    logic        ev_link;
    logic        ev_chain;
  } sdma_top_s;

  sdma_top_s   s, next_s;
  sdma_desc_s  desc;
  logic [31:0] ram_rd;
  logic [31:0] rd_mux;
  logic [1:0]  irq_stat;
  logic [1:0]  irq_mask;
  logic [1:0]  irq_clr;
  logic [AW-1:0] ram_idx;
  logic        req;
  logic        fire;
  logic        in_desc;
  logic        ram_we;
  logic        mask_we;
  logic        wr_free;
  logic        consume;
  logic        irq_q;

  function automatic logic [12:0] mps_bytes(input logic [2:0] code);
    case (code)
      3'h0:    return 13'h0080;
      3'h1:    return 13'h0100;
      3'h2:    return 13'h0200;
      3'h3:    return 13'h0400;
      3'h4:    return 13'h0800;
      default: return 13'h1000;
    endcase
  endfunction : mps_bytes

  function automatic logic [3:0] beat_keep(input logic [2:0] n);
    case (n)
      3'h1:    return 4'h1;
      3'h2:    return 4'h3;
      3'h3:    return 4'h7;
      default: return 4'hF;
    endcase
  endfunction : beat_keep

  // Bus handshake: one wait cycle, then the access completes
  assign req     = avs_i.read | avs_i.write;
  assign fire    = req & ~s.wreq;
  assign in_desc = (avs_i.address >= `SDMA_DESC_BASE) &&
                   (avs_i.address < 12'(`SDMA_DESC_BASE + DESC_NUM * `SDMA_DESC_BYTES));
  assign ram_idx = AW'((avs_i.address - `SDMA_DESC_BASE) >> 2);
  assign ram_we  = fire & avs_i.write & in_desc;
  assign mask_we = fire & avs_i.write & (avs_i.address == `SDMA_IRQ_MASK_OFS);
  // Only bits already reported are cleared, late events stay pending
  assign irq_clr = (fire && avs_i.read && avs_i.address == `SDMA_IRQ_STAT_OFS) ? s.rdata[1:0] : 2'h0;
  assign wr_free = ~s.wr.valid | wr_ready_i;
  assign consume = st_i.valid & s.rdy;

  sdma_desc_ram #(
    .DESC_NUM (DESC_NUM),
    .AW       (AW),
    .LW       (LW)
  ) u_ram (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .we_i       (ram_we),
    .idx_i      (ram_idx),
    .wdata_i    (avs_i.writedata),
    .be_i       (avs_i.byteenable),
    .rdata_o    (ram_rd),
    .link_i     (s.link),
    .desc_o     (desc)
  );

  sdma_irq #(
    .N (2)
  ) u_irq (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .set_i      ({s.ev_chain, s.ev_link}),
    .clr_i      (irq_clr),
    .mask_we_i  (mask_we),
    .mask_i     (avs_i.writedata[1:0]),
    .status_o   (irq_stat),
    .mask_o     (irq_mask),
    .irq_o      (irq_q)
  );

  always_comb begin
    rd_mux = 32'h0;
    if (in_desc) begin
      rd_mux = ram_rd;
    end else begin
      case (avs_i.address)
        `SDMA_CTRL_OFS:     rd_mux = {31'h0, s.fsm != SDMA_IDLE};
        `SDMA_STAT_OFS:     rd_mux = {s.loops[15:0], 8'(s.link), 1'b0, s.fsm};
        `SDMA_IRQ_STAT_OFS: rd_mux = {30'h0, irq_stat};
        `SDMA_IRQ_MASK_OFS: rd_mux = {30'h0, irq_mask};
        `SDMA_GO_OFS:       rd_mux = {31'h0, s.go};
        default:            rd_mux = 32'h0;
      endcase
    end
  end

  always_comb begin
    logic [2:0]  k;
    logic        fin;
    logic [12:0] rsum;
    logic [63:0] nbase;
    k        = (s.left < 32'h4) ? s.left[2:0] : `SDMA_BEAT_BYTES;
    fin      = (s.left <= 32'h4) || (s.d.flags[`SDMA_F_EOP] && s.beat.eop);
    rsum     = s.req + 13'(k);
    nbase    = s.base + 64'(s.d.incr);
    next_s   = s;
    next_s.ev_link  = 1'b0;
    next_s.ev_chain = 1'b0;
    next_s.wreq     = 1'b1;
    if (req && s.wreq) begin
      next_s.wreq  = 1'b0;
      next_s.rdata = rd_mux;
    end
    if (s.wr.valid && wr_ready_i) next_s.wr.valid = 1'b0;
    case (s.fsm)
      SDMA_IDLE: begin
        if (fire && avs_i.write && avs_i.address == `SDMA_CTRL_OFS && avs_i.writedata[`SDMA_CTRL_RUN_BIT]) begin
          next_s.link = avs_i.writedata[`SDMA_CTRL_LINK_LSB +: LW];
          next_s.fsm  = SDMA_LOAD;
        end
      end
      SDMA_LOAD: begin
        next_s.d    = desc;
        next_s.base = desc.dst;
        next_s.addr = desc.dst;
        next_s.mptr = desc.meta;
        next_s.loops = (desc.flags[`SDMA_F_INCR] && desc.loops != 32'h0) ? desc.loops : 32'h1;
        next_s.go   = 1'b0;
        next_s.fsm  = SDMA_GO;
      end
      SDMA_GO: begin
        next_s.left  = s.d.bytes;
        next_s.req   = 13'h0;
        next_s.armed = s.d.flags[`SDMA_F_SOP];
        if (s.d.flags[`SDMA_F_AUTO] || s.go) begin
          next_s.go  = 1'b0;
          next_s.fsm = (s.d.bytes == 32'h0) ? SDMA_DONE : SDMA_XFER;
        end
      end
      SDMA_XFER: begin
        if (consume) begin
          next_s.beat = st_i;
          if (!s.armed || st_i.sop) begin
            next_s.armed = 1'b0;
            next_s.fsm = (s.d.flags[`SDMA_F_WMETA] && st_i.sop) ? SDMA_META : SDMA_DATA;
          end
        end
      end
      SDMA_META: begin
        if (wr_free) begin
          next_s.wr   = '{valid: 1'b1, first: 1'b1, last: 1'b1, addr: s.mptr, keep: 4'hF, data: s.beat.meta};
          next_s.mptr = s.mptr + `SDMA_META_STEP;
          next_s.fsm  = SDMA_DATA;
        end
      end
      SDMA_DATA: begin
        if (wr_free) begin
          next_s.wr.last  = fin || (rsum >= mps_bytes(mps_i));
          next_s.wr.valid = 1'b1;
          next_s.wr.first = (s.req == 13'h0);
          next_s.wr.addr  = s.addr;
          next_s.wr.keep  = beat_keep(k);
          next_s.wr.data  = s.beat.data;
          next_s.req      = next_s.wr.last ? 13'h0 : rsum;
          next_s.addr     = s.addr + 64'(k);
          next_s.left     = s.left - 32'(k);
          next_s.fsm      = fin ? SDMA_DONE : SDMA_XFER;
        end
      end
      SDMA_DONE: begin
        next_s.ev_link = s.d.flags[`SDMA_F_LINK_INT];
        if (s.loops > 32'h1) begin
          next_s.base  = nbase;
          next_s.addr  = nbase;
          next_s.loops = s.loops - 32'h1;
          next_s.fsm   = SDMA_GO;
        end else if (s.d.flags[`SDMA_F_CHAIN_END]) begin
          next_s.ev_chain = s.d.flags[`SDMA_F_CHAIN_INT];
          next_s.loops    = 32'h0;
          next_s.fsm      = SDMA_IDLE;
        end else begin
          next_s.link = (s.link == LW'(DESC_NUM - 1)) ? '0 : s.link + 1'b1;
          next_s.fsm  = SDMA_LOAD;
        end
      end
      default: next_s.fsm = SDMA_IDLE;
    endcase
    // Go written late still counts, set after the clear above
    if (fire && avs_i.write && avs_i.address == `SDMA_GO_OFS && avs_i.writedata[`SDMA_GO_BIT]) next_s.go = 1'b1;
    next_s.rdy = (next_s.fsm == SDMA_XFER);
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s      <= '0;
      s.fsm  <= SDMA_IDLE;
      s.wreq <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign avs_readdata_o    = s.rdata;
  assign avs_waitrequest_o = s.wreq;
  assign st_ready_o        = s.rdy;
  assign wr_o              = s.wr;
  assign irq_o             = irq_q;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  wait_pulse_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low for more than one cycle");
  man_hold_a: assert property (
    s.fsm == SDMA_GO && !s.d.flags[`SDMA_F_AUTO] && !s.go |=> s.fsm == SDMA_GO)
    else $error("manual descriptor started without go");
  meta_off_a: assert property (s.fsm == SDMA_META |-> s.d.flags[`SDMA_F_WMETA])
    else $error("metadata sent while disabled");
  meta_addr_a: assert property (
    s.fsm == SDMA_META && wr_free |=> wr_o.valid && wr_o.addr == $past(s.mptr) && wr_o.first)
    else $error("metadata request at wrong address");
  dst_start_a: assert property (s.fsm == SDMA_LOAD |=> s.addr == $past(desc.dst))
    else $error("data does not start at destination");
  byte_exact_a: assert property (
    s.fsm == SDMA_DONE && !s.d.flags[`SDMA_F_EOP] |-> s.left == 32'h0)
    else $error("execution ended with bytes left");
  loop_repeat_a: assert property (s.fsm == SDMA_DONE && s.loops > 32'h1 |=>
    s.fsm == SDMA_GO && s.link == $past(s.link) && s.loops == $past(s.loops) - 32'h1)
    else $error("loop did not repeat the same link");
  loop_incr_a: assert property (
    s.fsm == SDMA_DONE && s.loops > 32'h1 |=> s.addr == $past(s.base) + $past(s.d.incr))
    else $error("destination not advanced by increment");
  sop_skip_a: assert property (s.armed && consume && !st_i.sop |=> s.fsm == SDMA_XFER && s.armed)
    else $error("data taken before packet start");
  eop_end_a: assert property (
    s.fsm == SDMA_DATA && wr_free && s.d.flags[`SDMA_F_EOP] && s.beat.eop |=> s.fsm == SDMA_DONE)
    else $error("transfer not ended at packet end");
  link_irq_a: assert property (
    s.fsm == SDMA_DONE && s.d.flags[`SDMA_F_LINK_INT] |=> s.ev_link ##1 irq_stat[`SDMA_IRQ_LINK_BIT])
    else $error("link interrupt not raised");
  chain_irq_a: assert property (s.fsm == SDMA_DONE && s.loops <= 32'h1 &&
    s.d.flags[`SDMA_F_CHAIN_END] && s.d.flags[`SDMA_F_CHAIN_INT] |=> s.ev_chain && s.fsm == SDMA_IDLE)
    else $error("chain interrupt not raised");
  chain_next_a: assert property (
    s.fsm == SDMA_DONE && s.loops <= 32'h1 && !s.d.flags[`SDMA_F_CHAIN_END] |=> s.fsm == SDMA_LOAD)
    else $error("chain did not continue");
  mps_limit_a: assert property (s.req < mps_bytes(mps_i))
    else $error("request payload above maximum");
  // Start, loop count, stream and PCIe handshake checks
  auto_start_a: assert property (
    s.fsm == SDMA_GO && (s.d.flags[`SDMA_F_AUTO] || s.go) |=> s.fsm == SDMA_XFER || s.fsm == SDMA_DONE)
    else $error("released descriptor did not start");
  loop_count_a: assert property (s.fsm == SDMA_LOAD |=>
    s.loops == (($past(desc.flags[`SDMA_F_INCR]) && $past(desc.loops) != 32'h0) ? $past(desc.loops) : 32'h1))
    else $error("loop count not taken from descriptor");
  ready_drop_a: assert property (
    consume && (!s.armed || st_i.sop) |=> !st_ready_o)
    else $error("stream ready held after a used beat");
  // A beat lost under stall would break the byte count
  wr_hold_a: assert property (
    wr_o.valid && !wr_ready_i |=> wr_o.valid && $stable(wr_o))
    else $error("write beat changed while stalled");
endmodule : sdma_top

// [sim/sdma_pcie_sink.sv]
// Behavioural PCIe core model that takes write beats and keeps tallies
`timescale 1ns/100ps
module sdma_pcie_sink (
  // Clock and reset
  input  wire logic                 core_clk_i,
  input  wire logic                 sys_rst_i,
  // Tally clear and payload limit
  input  wire logic                 clr_i,
  input  wire logic [2:0]           mps_i,
  // Write beats
  input  wire sdma_pkg::sdma_wr_s   wr_i,
  output logic                      ready_o,
  // Tallies
  output logic      [31:0]          beats_o,
  output logic      [31:0]          bytes_o,
  output logic      [31:0]          firsts_o,
  output logic      [63:0]          last_addr_o,
  output logic      [31:0]          first_data_o,
  output logic      [31:0]          over_o
);
  import sdma_pkg::*;
  logic [1:0]  ph;
  logic [31:0] pay;
  logic [31:0] lim;
  logic [31:0] n;
  // Stalls one cycle in four, so the engine must hold its beat
  assign ready_o = (ph != 2'h3);
  assign lim     = (mps_i > 3'h5) ? 32'h1000 : (32'h80 << mps_i);
  assign n       = 32'($countones(wr_i.keep));
  always @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ph <= 2'h0;
      pay <= 32'h0;
      {beats_o, bytes_o, firsts_o, last_addr_o, first_data_o, over_o} <= '0;
    end else begin
      ph <= ph + 2'h1;
      if (clr_i) begin
        {beats_o, bytes_o, firsts_o, last_addr_o, first_data_o, over_o} <= '0;
      end else if (wr_i.valid && ready_o) begin
        beats_o <= beats_o + 32'h1;
        bytes_o <= bytes_o + n;
        firsts_o <= firsts_o + 32'(wr_i.first);
        last_addr_o <= wr_i.addr;
        if (beats_o == 32'h0) first_data_o <= wr_i.data;
        pay <= (wr_i.first ? 32'h0 : pay) + n;
        if ((wr_i.first ? 32'h0 : pay) + n > lim) over_o <= over_o + 32'h1;
      end
    end
  end
endmodule : sdma_pcie_sink

// [sim/stream_to_pcie_link_descriptor_dma_test.sv]
// Self-checking bench for the stream-to-PCIe descriptor DMA
`timescale 1ns/100ps
`include "sdma_regs.svh"
module stream_to_pcie_link_descriptor_dma_test;
  import sdma_pkg::*;
  typedef struct packed {
    logic [31:0] bytes;
    logic [7:0]  flags;
    logic [31:0] loops;
    logic [2:0]  mps;
    logic [31:0] beats;
    logic [31:0] nbytes;
    logic [31:0] firsts;
    logic [63:0] last;
    logic [31:0] data;
    logic [1:0]  irq;
  } sdma_row_s;
  localparam logic [63:0] DST  = 64'h0000_0002_1000_0000;
  localparam logic [63:0] META = 64'h0000_0003_2000_0000;
  logic core_clk_i = 1'b0;
  logic sys_rst_i  = 1'b1;
  sdma_avm_s avs = '0;
  logic [31:0] avs_rd, rd;
  logic wreq, st_ready, wr_ready, irq, restart = 1'b0, st_en = 1'b0;
  logic [2:0] mps = 3'h5;
  logic [31:0] k = 32'h0;
  sdma_beat_s st;
  sdma_wr_s wr;
  logic [31:0] beats, nbytes, firsts, fdata, over;
  logic [63:0] laddr;
  int n_mismatch = 0;
  int n_checks = 0;
  sdma_row_s rows [7] = '{
    '{32'd8, 8'hE1, 32'd0, 3'h5, 32'd2, 32'd8, 32'd1, DST + 64'h4, 32'hA000_0000, 2'h3},
    '{32'd6, 8'h81, 32'd0, 3'h5, 32'd2, 32'd6, 32'd1, DST + 64'h4, 32'hA000_0000, 2'h0},
    '{32'd4, 8'hA5, 32'd3, 3'h5, 32'd3, 32'd12, 32'd3, DST + 64'h800, 32'hA000_0000, 2'h1},
    '{32'd4, 8'h8B, 32'd0, 3'h5, 32'd2, 32'd8, 32'd2, DST, 32'hB000_0001, 2'h0},
    '{32'd4, 8'h89, 32'd0, 3'h5, 32'd1, 32'd4, 32'd1, DST, 32'hA000_0001, 2'h0},
    '{32'd64, 8'h91, 32'd0, 3'h5, 32'd3, 32'd12, 32'd1, DST + 64'h8, 32'hA000_0000, 2'h0},
    '{32'd256, 8'h81, 32'd0, 3'h0, 32'd64, 32'd256, 32'd2, DST + 64'hFC, 32'hA000_0000, 2'h0}
  };
  always #5 core_clk_i = ~core_clk_i;
  // Endless beat source; sop on every fourth beat from 1, eop from 2
  assign st = '{valid: st_en, sop: (k[1:0] == 2'h1), eop: (k[1:0] == 2'h2),
                meta: 32'hB000_0000 + k, data: 32'hA000_0000 + k};
  always @(posedge core_clk_i) begin
    if (restart) k <= 32'h0;
    else if (st.valid && st_ready) k <= k + 32'h1;
  end
  sdma_top #(.DESC_NUM(16)) i_dut (
    .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .avs_i(avs), .avs_readdata_o(avs_rd),
    .avs_waitrequest_o(wreq), .st_i(st), .st_ready_o(st_ready), .wr_o(wr), .wr_ready_i(wr_ready),
    .mps_i(mps), .irq_o(irq));
  sdma_pcie_sink i_sink (
    .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .clr_i(restart), .mps_i(mps), .wr_i(wr),
    .ready_o(wr_ready), .beats_o(beats), .bytes_o(nbytes), .firsts_o(firsts), .last_addr_o(laddr),
    .first_data_o(fdata), .over_o(over));
  task automatic summarize;
    if (n_mismatch == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      n_mismatch++;
    end
  endtask : chk
  task automatic bus(input logic is_rd, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
    int i;
    @(posedge core_clk_i);
    avs <= '{address: a, read: is_rd, write: !is_rd, byteenable: 4'hF, writedata: d};
    for (i = 0; i < 50; i++) begin
      @(posedge core_clk_i);
      if (wreq === 1'b0) break;
    end
    q = avs_rd;
    avs <= '0;
    if (i == 50) begin
      n_mismatch++;
      summarize();
    end
  endtask : bus
  task automatic desc(input logic [3:0] l, input logic [63:0] d, input logic [31:0] b, input logic [7:0] f,
                      input logic [31:0] lp);
    logic [31:0] w [8];
    logic [31:0] q;
    w = '{d[31:0], d[63:32], META[31:0], META[63:32], b, {24'h0, f}, lp, 32'h400};
    for (int i = 0; i < 8; i++) bus(1'b0, `SDMA_DESC_BASE + 12'(l) * 12'h20 + 12'(i * 4), w[i], q);
  endtask : desc
  task automatic wait_done;
    logic [31:0] q;
    for (int i = 0; i < 3000; i++) begin
      bus(1'b1, `SDMA_CTRL_OFS, 32'h0, q);
      if (q[0] === 1'b0 && wr.valid === 1'b0) return;
    end
    n_mismatch++;
    summarize();
  endtask : wait_done
  task automatic fresh;
    @(posedge core_clk_i);
    restart <= 1'b1;
    @(posedge core_clk_i);
    restart <= 1'b0;
  endtask : fresh
  initial begin
    repeat (4) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    st_en <= 1'b1;
    chk(irq, 1'b0);
    chk(wr.valid, 1'b0);
    chk(wreq, 1'b1);
    chk(st_ready, 1'b0);
    chk(avs_rd, 32'h0);
    bus(1'b1, `SDMA_IRQ_MASK_OFS, 32'h0, rd);
    chk(rd, `SDMA_IRQ_MASK_RST);
    bus(1'b1, `SDMA_IRQ_STAT_OFS, 32'h0, rd);
    chk(rd, `SDMA_IRQ_STAT_RST);
    // Unmapped place reads zero even after a write
    bus(1'b0, 12'h050, 32'hFFFF_FFFF, rd);
    bus(1'b1, 12'h050, 32'h0, rd);
    chk(rd, 32'h0);
    for (int r = 0; r < 7; r++) begin
      @(posedge core_clk_i);
      mps <= rows[r].mps;
      fresh();
      desc(4'h0, DST, rows[r].bytes, rows[r].flags, rows[r].loops);
      bus(1'b0, `SDMA_CTRL_OFS, 32'h1, rd);
      wait_done();
      chk(beats, rows[r].beats);
      chk(nbytes, rows[r].nbytes);
      chk(firsts, rows[r].firsts);
      chk(laddr, rows[r].last);
      chk(fdata, rows[r].data);
      chk(over, 32'h0);
      chk(irq, 1'b0);
      bus(1'b1, `SDMA_IRQ_STAT_OFS, 32'h0, rd);
      chk(rd[1:0], rows[r].irq);
    end
    // Manual descriptor waits for the go write
    fresh();
    desc(4'h0, DST, 32'd4, 8'h80, 32'd0);
    bus(1'b0, `SDMA_CTRL_OFS, 32'h1, rd);
    repeat (40) @(posedge core_clk_i);
    chk(beats, 32'h0);
    bus(1'b0, `SDMA_GO_OFS, 32'h1, rd);
    wait_done();
    chk(beats, 32'h1);
    // Two-link chain with both interrupts unmasked
    fresh();
    bus(1'b0, `SDMA_IRQ_MASK_OFS, 32'h3, rd);
    desc(4'h0, DST, 32'd4, 8'h21, 32'd0);
    desc(4'h1, DST + 64'h1000, 32'd4, 8'hC1, 32'd0);
    bus(1'b0, `SDMA_CTRL_OFS, 32'h1, rd);
    wait_done();
    chk(beats, 32'h2);
    chk(laddr, DST + 64'h1000);
    chk(irq, 1'b1);
    bus(1'b1, `SDMA_IRQ_STAT_OFS, 32'h0, rd);
    chk(rd[1:0], 2'h3);
    @(posedge core_clk_i);
    chk(irq, 1'b0);
    bus(1'b1, `SDMA_IRQ_STAT_OFS, 32'h0, rd);
    chk(rd[1:0], 2'h0);
    // Stopped on link 1, idle, no loops left
    bus(1'b1, `SDMA_STAT_OFS, 32'h0, rd);
    chk(rd, 32'h0000_0101);
    summarize();
  end
endmodule : stream_to_pcie_link_descriptor_dma_test
